// [rts_reset_timeout_sequencer.sv]
/*
  Reset and time-out sequencer: power-on and brown-out handling, power-up
  delay on rc ticks, oscillator start-up count, reset cause flags, AXI4-Lite
  registers. Assumes analog monitors and oscillators arrive as raw pins and
  that the cpu drives sleep, wake and watchdog pulses on aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module rts_reset_timeout_sequencer
  import rts_pkg::*;
#(
  parameter int unsigned ADDR_W   = 12,
  parameter int unsigned POWER_UP_DELAY_TIMER_CYC = POWER_UP_DELAY_TIMER_RC_CYC,
  parameter int unsigned BOR_QUAL = BOR_QUAL_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              por_n,
  input  wire logic              supply_below_threshold,
  input  wire logic              external_reset_pin_n,
  input  wire logic              rc_osc_clk,
  input  wire logic              sys_osc_clk,
  input  wire logic              sleep_req,
  input  wire logic              wake_irq,
  input  wire logic              wdt_timeout,
  output logic                   core_reset_n,
  output logic                   brown_out_detect_en,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);
  localparam int unsigned PW = $clog2(POWER_UP_DELAY_TIMER_CYC + 1);
  localparam int unsigned QW = $clog2(BOR_QUAL + 1);
  localparam int unsigned OW = $clog2(OST_CYC);
  localparam logic [PW-1:0] POWER_UP_DELAY_TIMER_LAST = PW'(POWER_UP_DELAY_TIMER_CYC - 1);
  localparam logic [QW-1:0] QUAL_FULL = QW'(BOR_QUAL);
  localparam logic [OW-1:0] OST_LAST  = OW'(OST_CYC - 1);

  rts_state_t      state_q;
  logic [NPIN-1:0] sync1_q, sync2_q, sync3_q;
  logic [PW-1:0]   power_up_delay_timer_cnt_q;
  logic [OW-1:0]   ost_cnt_q;
  logic [QW-1:0]   qual_cnt_q;
  logic [2:0]      osc_mode_q;
  logic            power_up_delay_timer_dis_q;
  logic [1:0]      bor_mode_q;
  logic            to_q, pd_q, por_flag_q, bor_flag_q;
  logic            aw_full_q, w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]     wdata_q;
  logic [3:0]      wstrb_q;

  logic por_low, supply_low, ext_low, rc_tick, osc_tick;
  logic brown_out, supply_ok, is_xtal, wr_go, aw_full_d;
  logic w_full_d, rvalid_d, ar_take, power_control_reset_cause_wr, cfg_wr;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] i);
    return a[IDX_W+1:2] == i;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return reg_hit(a, CFG_IDX) || reg_hit(a, STATUS_IDX) || reg_hit(a, POWER_CONTROL_RESET_CAUSE_IDX);
  endfunction

  // pins pass two flops; edges taken between second and third
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {sys_osc_clk, rc_osc_clk, external_reset_pin_n,
                  supply_below_threshold, por_n};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign por_low    = ~sync2_q[PIN_POR];
  assign supply_low = sync2_q[PIN_BOR];
  assign ext_low    = ~sync2_q[PIN_EXT];
  assign rc_tick    = sync2_q[PIN_RC] & ~sync3_q[PIN_RC];
  assign osc_tick   = sync2_q[PIN_OSC] & ~sync3_q[PIN_OSC];
  assign is_xtal    = osc_mode_q < OSC_EC;
  assign brown_out  = qual_cnt_q == QUAL_FULL;
  assign supply_ok  = ~(brown_out_detect_en & supply_low);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // detector enable per mode and sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brown_out_detect_en <= 1'b0;
    end else begin
      brown_out_detect_en <= (bor_mode_q == BOR_ON) ||
                             (bor_mode_q == BOR_RUN && state_q != ST_SLEEP);
    end
  end
  bor_mode_a: assert property (
    (state_q == ST_SLEEP && bor_mode_q == BOR_RUN) [*2] |-> !brown_out_detect_en)
    else $error("detector on in sleep with run-only mode");

  // low supply must persist for the qualification time
  always_ff @(posedge aclk) begin
    if (!aresetn || !brown_out_detect_en || !supply_low) begin
      qual_cnt_q <= '0;
    end else if (!brown_out) begin
      qual_cnt_q <= qual_cnt_q + QW'(1);
    end
  end
  bor_qual_a: assert property (
    $rose(brown_out) |-> $past(supply_low) && $past(qual_cnt_q) == QUAL_FULL - QW'(1))
    else $error("brown-out without qualified low supply");

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_HOLD;
    end else if (por_low || brown_out) begin
      state_q <= ST_HOLD;
    end else begin
      case (state_q)
        ST_HOLD: begin
          if (supply_ok) begin
            if (!power_up_delay_timer_dis_q) begin
              state_q <= ST_POWER_UP_DELAY_TIMER;
            end else if (is_xtal) begin
              state_q <= ST_OST;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_POWER_UP_DELAY_TIMER: begin
          if (rc_tick && power_up_delay_timer_cnt_q == POWER_UP_DELAY_TIMER_LAST) begin
            state_q <= is_xtal ? ST_OST : ST_RUN;
          end
        end
        ST_OST: begin
          if (osc_tick && ost_cnt_q == OST_LAST) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (sleep_req) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_irq || wdt_timeout || ext_low) begin
            state_q <= is_xtal ? ST_OST : ST_RUN;
          end
        end
        default: state_q <= ST_HOLD;
      endcase
    end
  end

  power_up_delay_timer_skip_a: assert property (
    state_q == ST_HOLD && supply_ok && !por_low && !brown_out
    |=> (state_q == ST_POWER_UP_DELAY_TIMER) == !$past(power_up_delay_timer_dis_q))
    else $error("power-up delay not taken as configured");

  // delay counter advances only on rc ticks
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != ST_POWER_UP_DELAY_TIMER || por_low || brown_out) begin
      power_up_delay_timer_cnt_q <= '0;
    end else if (rc_tick) begin
      power_up_delay_timer_cnt_q <= power_up_delay_timer_cnt_q + PW'(1);
    end
  end
  power_up_delay_timer_rc_a: assert property (
    state_q == ST_POWER_UP_DELAY_TIMER && !rc_tick && !por_low && !brown_out |=> $stable(power_up_delay_timer_cnt_q))
    else $error("delay counter moved without rc tick");

  power_up_delay_timer_length_a: assert property (
    state_q == ST_POWER_UP_DELAY_TIMER ##1 state_q != ST_POWER_UP_DELAY_TIMER && state_q != ST_HOLD
    |-> $past(power_up_delay_timer_cnt_q) == POWER_UP_DELAY_TIMER_LAST && $past(rc_tick))
    else $error("power-up delay ended early");

  bor_restart_a: assert property (
    brown_out |=> state_q == ST_HOLD && power_up_delay_timer_cnt_q == '0)
    else $error("brown-out did not clear the delay");

  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != ST_OST || por_low || brown_out) begin
      ost_cnt_q <= '0;
    end else if (osc_tick) begin
      ost_cnt_q <= ost_cnt_q + OW'(1);
    end
  end
  ost_xtal_a: assert property (
    $rose(state_q == ST_OST) |-> $past(is_xtal))
    else $error("oscillator count in non-crystal mode");

  ost_length_a: assert property (
    state_q == ST_OST ##1 state_q == ST_RUN |-> $past(ost_cnt_q) == OST_LAST)
    else $error("oscillator count ended early");

  // pin gates the core and wakes from sleep; delays run regardless
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= (state_q == ST_RUN || state_q == ST_SLEEP) && !ext_low &&
                      !(wdt_timeout && state_q == ST_RUN);
    end
  end
  hold_in_power_up_delay_timer_a: assert property (
    state_q == ST_POWER_UP_DELAY_TIMER |=> !core_reset_n)
    else $error("core released during power-up delay");

  ext_release_a: assert property (
    state_q == ST_RUN && !ext_low && !wdt_timeout |=> core_reset_n)
    else $error("core not released after pin release");

  always_ff @(posedge aclk) begin
    if (!aresetn || por_low || brown_out) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (state_q == ST_RUN && wdt_timeout) begin
      to_q <= 1'b0;
    end else if (state_q == ST_SLEEP && wdt_timeout) begin
      to_q <= 1'b0;
      pd_q <= 1'b0;
    end else if (state_q == ST_SLEEP && ext_low) begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end else if (state_q == ST_RUN && sleep_req) begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end
  end

  flags_por_a: assert property (
    por_low |=> to_q && pd_q && !por_flag_q)
    else $error("power-on flags wrong");

  // hardware clear wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || por_low) begin
      por_flag_q <= 1'b0;
    end else if (power_control_reset_cause_wr) begin
      por_flag_q <= wdata_q[POWER_CONTROL_RESET_CAUSE_POR_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || brown_out) begin
      bor_flag_q <= 1'b0;
    end else if (power_control_reset_cause_wr) begin
      bor_flag_q <= wdata_q[POWER_CONTROL_RESET_CAUSE_BOR_BIT];
    end
  end
  bor_flag_a: assert property (
    brown_out |=> !bor_flag_q)
    else $error("brown-out flag not cleared");

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_mode_q <= OSC_RST;
      power_up_delay_timer_dis_q <= POWER_UP_DELAY_TIMER_RST;
      bor_mode_q <= BOR_RST;
    end else if (cfg_wr) begin
      if (wstrb_q[0]) begin
        osc_mode_q <= wdata_q[CFG_OSC_LSB +: 3];
        power_up_delay_timer_dis_q <= wdata_q[CFG_POWER_UP_DELAY_TIMER_BIT];
      end
      if (wstrb_q[1]) begin
        bor_mode_q <= wdata_q[CFG_BOR_LSB +: 2];
      end
    end
  end

  // write channel: address and data latched independently
  assign wr_go     = aw_full_q && w_full_q && !bvalid;
  assign aw_full_d = (aw_full_q && !wr_go) || (awvalid && awready);
  assign w_full_d  = (w_full_q && !wr_go) || (wvalid && wready);
  assign power_control_reset_cause_wr   = wr_go && reg_hit(aw_addr_q, POWER_CONTROL_RESET_CAUSE_IDX) && wstrb_q[0];
  assign cfg_wr    = wr_go && reg_hit(aw_addr_q, CFG_IDX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_addr_q <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready   <= !aw_full_d;
      wready    <= !w_full_d;
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel
  assign ar_take  = arvalid && arready;
  assign rvalid_d = (rvalid && !rready) || ar_take;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalid_d;
      rvalid  <= rvalid_d;
      if (ar_take) begin
        rdata <= '0;
        rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        if (reg_hit(araddr, POWER_CONTROL_RESET_CAUSE_IDX)) begin
          rdata[POWER_CONTROL_RESET_CAUSE_POR_BIT] <= por_flag_q;
          rdata[POWER_CONTROL_RESET_CAUSE_BOR_BIT] <= bor_flag_q;
        end
        if (reg_hit(araddr, STATUS_IDX)) begin
          rdata[STAT_TO_BIT] <= to_q;
          rdata[STAT_PD_BIT] <= pd_q;
        end
        if (reg_hit(araddr, CFG_IDX)) begin
          rdata[CFG_OSC_LSB +: 3] <= osc_mode_q;
          rdata[CFG_POWER_UP_DELAY_TIMER_BIT]     <= power_up_delay_timer_dis_q;
          rdata[CFG_BOR_LSB +: 2] <= bor_mode_q;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rts_pkg.sv]
/*
  Constants, register map and types of the reset and time-out sequencer.
  Assumes a single 200 MHz bus clock and an AXI4-Lite register bus.
*/
package rts_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RC_HZ         = 31_000;
  localparam int unsigned POWER_UP_DELAY_TIMER_TIME_MS  = 64;
  localparam int unsigned POWER_UP_DELAY_TIMER_RC_CYC   = POWER_UP_DELAY_TIMER_TIME_MS * RC_HZ / 1000;
  localparam int unsigned OST_CYC       = 1024;
  localparam int unsigned BOR_QUAL_NS   = 100;
  localparam int unsigned BOR_QUAL_CYC  = (BOR_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned IDX_W = 10;
  localparam logic [IDX_W-1:0] CFG_IDX    = 10'h080;
  localparam logic [IDX_W-1:0] STATUS_IDX = 10'h083;
  localparam logic [IDX_W-1:0] POWER_CONTROL_RESET_CAUSE_IDX   = 10'h08e;

  localparam int unsigned POWER_CONTROL_RESET_CAUSE_BOR_BIT = 0;
  localparam int unsigned POWER_CONTROL_RESET_CAUSE_POR_BIT = 1;
  localparam int unsigned STAT_PD_BIT  = 3;
  localparam int unsigned STAT_TO_BIT  = 4;
  localparam int unsigned CFG_OSC_LSB  = 0;
  localparam int unsigned CFG_POWER_UP_DELAY_TIMER_BIT = 4;
  localparam int unsigned CFG_BOR_LSB  = 8;

  localparam logic [2:0] OSC_RST  = 3'h4;
  localparam logic [2:0] OSC_EC   = 3'h3;
  localparam logic       POWER_UP_DELAY_TIMER_RST = 1'h0;
  localparam logic [1:0] BOR_ON   = 2'h3;
  localparam logic [1:0] BOR_RUN  = 2'h2;
  localparam logic [1:0] BOR_RST  = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned PIN_POR = 0;
  localparam int unsigned PIN_BOR = 1;
  localparam int unsigned PIN_EXT = 2;
  localparam int unsigned PIN_RC  = 3;
  localparam int unsigned PIN_OSC = 4;
  localparam int unsigned NPIN    = 5;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h0,
    ST_POWER_UP_DELAY_TIMER  = 3'h1,
    ST_OST   = 3'h3,
    ST_RUN   = 3'h2,
    ST_SLEEP = 3'h6
  } rts_state_t;
endpackage

// [rts_far_model.sv]
/*
  Far-side model: supply monitors, reset pin with weak pull-up, rc and
  crystal oscillators. Assumes bench commands arrive on aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module rts_far_model #(
  parameter int RC_HALF  = 4,
  parameter int OSC_HALF = 2
) (
  input  wire logic aclk,
  input  wire logic power_on,
  input  wire logic supply_low,
  input  wire logic pin_low,
  output logic      por_n,
  output logic      supply_below_threshold,
  output logic      external_reset_pin_n,
  output logic      rc_osc_clk,
  output logic      sys_osc_clk
);
  int rc_cnt = 0;
  int osc_cnt = 0;
  initial begin
    por_n = 1'b0;
    supply_below_threshold = 1'b1;
    external_reset_pin_n = 1'b1;
    rc_osc_clk = 1'b0;
    sys_osc_clk = 1'b0;
  end
  always @(posedge aclk) begin
    por_n <= power_on;
    supply_below_threshold <= supply_low | ~power_on;
    // pull-up keeps the pin high when nobody drives it
    external_reset_pin_n <= ~pin_low;
    rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
    if (rc_cnt == RC_HALF - 1) rc_osc_clk <= ~rc_osc_clk;
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1) sys_osc_clk <= ~sys_osc_clk;
  end
endmodule
`default_nettype wire

// [tb_reset_timeout_sequencer.sv]
/*
  Bench for the reset sequencer: AXI4-Lite tasks and timed reset scenarios.
  Assumes the far-side model and the package constants.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_reset_timeout_sequencer import rts_pkg::*;;
  localparam int N_PW  = 8;
  localparam int PW_LO = 8 * (N_PW - 1);
  localparam int PW_HI = 8 * N_PW + 12;
  localparam int OS_LO = 4 * (OST_CYC - 1);
  localparam int OS_HI = 4 * OST_CYC + 16;
  localparam logic [11:0] A_CFG = {CFG_IDX, 2'h0};
  localparam logic [11:0] A_ST  = {STATUS_IDX, 2'h0};
  localparam logic [11:0] A_PC  = {POWER_CONTROL_RESET_CAUSE_IDX, 2'h0};
  logic aclk = 0, aresetn = 0, power_on = 0, supply_low = 0, pin_low = 0;
  logic [2:0] ev = 3'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic por_n, sbt, pin_n, rc, osc, core_reset_n, bod_en;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [1:0] md [3] = '{2'h2, 2'h0, 2'h1};
  int mismatches = 0, checks_done = 0, n;

  always #2.5 aclk = ~aclk;

  rts_far_model far (.aclk(aclk), .power_on(power_on), .supply_low(supply_low),
    .pin_low(pin_low), .por_n(por_n), .supply_below_threshold(sbt),
    .external_reset_pin_n(pin_n), .rc_osc_clk(rc), .sys_osc_clk(osc));
  rts_reset_timeout_sequencer #(.POWER_UP_DELAY_TIMER_CYC(N_PW), .BOR_QUAL(3)) dut (.aclk(aclk),
    .aresetn(aresetn), .por_n(por_n), .supply_below_threshold(sbt),
    .external_reset_pin_n(pin_n), .rc_osc_clk(rc), .sys_osc_clk(osc),
    .sleep_req(ev[0]), .wake_irq(ev[1]), .wdt_timeout(ev[2]),
    .core_reset_n(core_reset_n), .brown_out_detect_en(bod_en),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] rs);
    int t;
    bit got;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= dv; wstrb <= 4'hf; wvalid <= 1'b1;
    bready <= 1'b1;
    t = 0;
    got = 0;
    while (!got) begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp; bready <= 1'b0; got = 1;
      end
      if (t > 100) begin
        mismatches++; final_report;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
    int t;
    bit got;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    t = 0;
    got = 0;
    while (!got) begin
      @(posedge aclk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        dv = rdata; rs = rresp; rready <= 1'b0; got = 1;
      end
      if (t > 100) begin
        mismatches++; final_report;
      end
    end
  endtask
  task automatic chk_reg(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk32(nm, e, d);
    chk32(nm, {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  task automatic wait_core(input logic lvl, input int max);
    n = 0;
    while (core_reset_n !== lvl) begin
      @(posedge aclk);
      n++;
      if (n > max) begin
        mismatches++; final_report;
      end
    end
  endtask
  task automatic glitch(input int k);
    @(posedge aclk);
    supply_low <= 1'b1;
    tick(k);
    supply_low <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge aclk);
    ev[k] <= 1'b1;
    @(posedge aclk);
    ev[k] <= 1'b0;
  endtask
  function automatic logic [31:0] st(input logic to, input logic pd);
    return {27'h0, to, pd, 3'h0};
  endfunction

  initial begin
    tick(10);
    aresetn <= 1'b1;
    tick(4);
    chk_reg("cfg reset", A_CFG, 32'h0000_0304);
    chk1("core before power", 1'b0, core_reset_n);
    power_on <= 1'b1;
    wait_core(1'b1, 200);
    chk1("power-up delay", 1'b1, n >= PW_LO && n <= PW_HI);
    chk_reg("status power-on", A_ST, st(1, 1));
    rd(A_PC, d, r);
    chk32("power_control_reset_cause power bit", 32'h0, d & 32'h2);
    wr(A_PC, 32'h3, r);
    chk_reg("power_control_reset_cause software set", A_PC, 32'h3);
    $display("test power-up done");
    glitch(2);
    tick(20);
    chk1("short dip", 1'b1, core_reset_n);
    glitch(10);
    chk1("brown-out reset", 1'b0, core_reset_n);
    tick(30);
    glitch(10);
    wait_core(1'b1, 200);
    chk1("restarted delay", 1'b1, n >= PW_LO && n <= PW_HI);
    chk_reg("power_control_reset_cause brown-out", A_PC, 32'h2);
    chk_reg("status brown-out", A_ST, st(1, 1));
    wr(A_CFG, 32'h314, r);
    glitch(10);
    wait_core(1'b1, 30);
    chk1("delay skipped", 1'b1, n <= 12);
    $display("test brown-out done");
    pulse(2);
    tick(4);
    chk_reg("status wdt reset", A_ST, st(0, 1));
    pulse(0);
    tick(4);
    chk_reg("status sleep", A_ST, st(1, 0));
    chk1("detector mode 11 sleep", 1'b1, bod_en);
    pulse(2);
    tick(4);
    chk_reg("status wdt wake", A_ST, st(0, 0));
    chk1("wake no delay", 1'b1, core_reset_n);
    pulse(0);
    tick(4);
    pin_low <= 1'b1;
    tick(10);
    pin_low <= 1'b0;
    wait_core(1'b1, 20);
    chk_reg("status pin in sleep", A_ST, st(1, 0));
    pulse(2);
    tick(4);
    pin_low <= 1'b1;
    tick(8);
    chk1("pin holds core", 1'b0, core_reset_n);
    chk_reg("status pin running", A_ST, st(0, 0));
    pin_low <= 1'b0;
    wait_core(1'b1, 20);
    $display("test flags done");
    for (int i = 0; i < 3; i++) begin
      wr(A_CFG, {22'h0, md[i], 8'h14}, r);
      tick(3);
      chk1("detector running", md[i] == 2'h2, bod_en);
      pulse(0);
      tick(4);
      chk1("detector sleep", 1'b0, bod_en);
      pulse(1);
      tick(4);
      chk1("detector wake", md[i] == 2'h2, bod_en);
    end
    glitch(10);
    tick(2);
    chk1("detection off", 1'b1, core_reset_n);
    $display("test modes done");
    wr(A_CFG, 32'h301, r);
    glitch(10);
    wait_core(1'b1, 5000);
    chk1("delay then osc count", 1'b1, n >= PW_LO + OS_LO && n <= PW_HI + OS_HI);
    pulse(0);
    tick(4);
    pulse(1);
    wait_core(1'b0, 20);
    wait_core(1'b1, 5000);
    chk1("osc count on wake", 1'b1, n >= OS_LO - 8 && n <= OS_HI);
    wr(A_CFG, 32'h311, r);
    glitch(10);
    wait_core(1'b1, 5000);
    chk1("osc count only", 1'b1, n >= OS_LO && n <= OS_HI + 8);
    $display("test crystal done");
    wr(A_CFG, 32'h304, r);
    wr(A_PC, 32'h3, r);
    power_on <= 1'b0;
    pin_low <= 1'b1;
    tick(10);
    power_on <= 1'b1;
    tick(PW_HI + 20);
    chk1("pin held after delays", 1'b0, core_reset_n);
    pin_low <= 1'b0;
    wait_core(1'b1, 8);
    chk1("late release", 1'b1, n <= 6);
    rd(A_PC, d, r);
    chk32("power_control_reset_cause repower", 32'h0, d & 32'h2);
    wr(A_ST, 32'h0, r);
    chk_reg("status read-only", A_ST, st(1, 1));
    rd(12'h000, d, r);
    chk32("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(12'h004, 32'h1, r);
    chk32("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test repower done");
    final_report;
  end
endmodule
`default_nettype wire
